/* logic/pma_pkg.sv */
// package: register map, field positions and timing of the phy management block
package pma_pkg;
	localparam int ADDR_W = 16;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [13:0] IDX_LINK_STATE = 14'h3000;
	localparam logic [13:0] IDX_REG_SEL = 14'h3008;
	localparam logic [13:0] IDX_WDATA_LO = 14'h300C;
	localparam logic [13:0] IDX_WDATA_HI = 14'h300D;
	localparam logic [13:0] IDX_RDATA_LO = 14'h3010;
	localparam logic [13:0] IDX_RDATA_HI = 14'h3011;
	localparam logic [13:0] IDX_ACC_CMD = 14'h3014;
	localparam logic [13:0] IDX_DIV = 14'h3018;
	localparam logic [13:0] IDX_MODE = 14'h301C;
	localparam logic [13:0] IDX_PWR = 14'h301D;
	localparam logic [13:0] IDX_LOCK = 14'h3020;
	localparam logic [13:0] IDX_SYSCFG = 14'h3021;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam logic [7:0] PWR_RST = 8'h40;
	localparam logic LOCK_RST = 1'b0;
	localparam int PWR_RST_BIT = 0;
	localparam int PWR_TE_BIT = 3;
	localparam int PWR_PDN_BIT = 5;
	localparam int PWR_FIX_BIT = 6;
	localparam logic [6:0] HALF_32 = 7'h10;
	localparam logic [6:0] HALF_64 = 7'h20;
	localparam logic [6:0] HALF_128 = 7'h40;
	localparam logic [5:0] TA_BIT = 6'h2E;
	localparam logic [5:0] DATA_BIT = 6'h30;
	localparam logic [5:0] FRM_LAST = 6'h3F;
	localparam int CLK_PERIOD_NS = 10;
	localparam int PHY_RST_TIME_NS = 1000;
	localparam int PHY_RST_CYC = (PHY_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic {ENG_IDLE, ENG_RUN} pma_eng_e;
endpackage : pma_pkg

/* logic/pma_mdio_eng.sv */
// management frame engine: clock divider and serial shifter toward the phy
`timescale 1ns/1ps
module pma_mdio_eng import pma_pkg::*; #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic op_read_i,
	input wire logic [7:0] div_sel_i,
	input wire logic [4:0] reg_i,
	input wire logic [15:0] wdata_i,
	output logic done_o,
	output logic [15:0] rdata_o,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o,
	input wire logic mdio_i
);
	pma_eng_e st_q, st_d;
	logic [6:0] cnt_q, cnt_d, half_q, half_d;
	logic [5:0] bit_q, bit_d;
	logic [63:0] sh_q, sh_d, frame;
	logic [15:0] rd_q, rd_d;
	logic rdop_q, rdop_d, mdc_q, mdc_d, mdio_q, mdio_d, oe_q, oe_d, done_q, done_d, tick;

	always_comb begin
		frame = {32'hFFFFFFFF, 2'b01, (op_read_i ? 2'b10 : 2'b01), PHY_ADDR, reg_i, 2'b10, wdata_i};
		tick = (cnt_q == half_q - 7'h01);
		st_d = st_q;
		cnt_d = cnt_q;
		half_d = half_q;
		bit_d = bit_q;
		sh_d = sh_q;
		rd_d = rd_q;
		rdop_d = rdop_q;
		mdc_d = mdc_q;
		mdio_d = mdio_q;
		oe_d = oe_q;
		done_d = 1'b0;
		case (st_q)
			ENG_IDLE: begin
				if (start_i) begin
					st_d = ENG_RUN;
					sh_d = frame;
					bit_d = 6'h00;
					cnt_d = 7'h00;
					mdc_d = 1'b0;
					mdio_d = frame[63];
					oe_d = 1'b1;
					rdop_d = op_read_i;
					half_d = (div_sel_i == 8'h00) ? HALF_32 : ((div_sel_i == 8'h01) ? HALF_64 : HALF_128);
				end
			end
			ENG_RUN: begin
				cnt_d = tick ? 7'h00 : cnt_q + 7'h01;
				if (tick) begin
					mdc_d = ~mdc_q;
					// sample on the rising edge, the phy drives data after the falling one
					if (!mdc_q && rdop_q && bit_q >= DATA_BIT) begin
						rd_d = {rd_q[14:0], mdio_i};
					end
					if (mdc_q) begin
						if (bit_q == FRM_LAST) begin
							st_d = ENG_IDLE;
							oe_d = 1'b0;
							done_d = 1'b1;
						end else begin
							bit_d = bit_q + 6'h01;
							sh_d = {sh_q[62:0], 1'b0};
							mdio_d = sh_q[62];
							// release the line from turnaround on for reads
							oe_d = !rdop_q || (bit_q + 6'h01 < TA_BIT);
						end
					end
				end
			end
			default: st_d = ENG_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= ENG_IDLE;
			cnt_q <= 7'h00;
			half_q <= HALF_64;
			bit_q <= 6'h00;
			sh_q <= 64'h0;
			rd_q <= 16'h0000;
			rdop_q <= 1'b0;
			mdc_q <= 1'b0;
			mdio_q <= 1'b0;
			oe_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			half_q <= half_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			rdop_q <= rdop_d;
			mdc_q <= mdc_d;
			mdio_q <= mdio_d;
			oe_q <= oe_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;
	assign rdata_o = rd_q;
	assign mdc_o = mdc_q;
	assign mdio_o = mdio_q;
	assign mdio_oe_o = oe_q;

	mdc_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		st_q == ENG_IDLE |-> !mdc_o) else $error("mdc moves while idle");
	mdc_half_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(mdc_o) && half_q == HALF_32 |-> mdc_o [*8]) else $error("mdc high phase too short");
	ta_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		st_q == ENG_RUN && rdop_q && bit_q >= TA_BIT |-> !mdio_oe_o) else $error("read data phase driven");
endmodule : pma_mdio_eng

/* logic/pma_top.sv */
// phy management access controller: apb register file, mode, power and reset control
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module pma_top import pma_pkg::*; #(
	parameter int RST_CYC = PHY_RST_CYC,
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic phy_cable_off_i,
	input wire logic phy_half_dpx_i,
	input wire logic phy_speed10_i,
	input wire logic phy_link_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o,
	input wire logic mdio_i,
	output logic [2:0] phy_mode_o,
	output logic autoneg_o,
	output logic speed100_o,
	output logic full_dpx_o,
	output logic ten_base_te_o,
	output logic phy_power_down_o,
	output logic phy_hw_reset_o,
	output logic core_clk_25m_o
);
	////////////////////////////////////////////////////////////////////////////////
	// state
	logic [4:0] sel_q, sel_d;
	logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d, rcnt_q, rcnt_d;
	logic [7:0] cmd_q, cmd_d, div_q, div_d;
	logic [2:0] mode_q, mode_d;
	logic fix_q, fix_d, pdn_q, pdn_d, te_q, te_d, rst_q, rst_d;
	logic lock_q, lock_d, csel_q, csel_d, start_q, start_d;
	logic [31:0] rdo_q, rdo_d, rd_v;
	logic rdy_q, rdy_d, err_q, err_d, rd_ok;
	logic an_q, an_d, s100_q, s100_d, fdx_q, fdx_d, teo_q, teo_d, c25_q, c25_d;
	logic [13:0] idx;
	logic wr, eng_done;
	logic [15:0] eng_rdata;

	assign idx = paddr_i[ADDR_W-1:2];
	assign wr = psel_i & penable_i & rdy_q & pwrite_i;

	////////////////////////////////////////////////////////////////////////////////
	// read decode, registered in the setup phase so pready can rise next cycle
	always_comb begin
		rd_v = 32'h0;
		rd_ok = 1'b1;
		case (idx)
			IDX_LINK_STATE: rd_v[7:0] = {phy_cable_off_i, 1'b0, mode_q, phy_half_dpx_i, phy_speed10_i, phy_link_i};
			IDX_REG_SEL: rd_v[7:0] = {3'b000, sel_q};
			IDX_WDATA_LO: rd_v[15:0] = wdat_q;
			IDX_WDATA_HI: rd_v[7:0] = wdat_q[15:8];
			IDX_RDATA_LO: rd_v[15:0] = rdat_q;
			IDX_RDATA_HI: rd_v[7:0] = rdat_q[15:8];
			IDX_ACC_CMD: rd_v[7:0] = cmd_q;
			IDX_DIV: rd_v[7:0] = div_q;
			IDX_MODE: rd_v = 32'h0;
			IDX_PWR: rd_v[7:0] = {1'b0, fix_q, pdn_q, 1'b0, te_q, 2'b00, rst_q};
			IDX_LOCK: rd_v[0] = lock_q;
			IDX_SYSCFG: rd_v[0] = csel_q;
			default: rd_ok = 1'b0;
		endcase
	end

	always_comb begin
		rdy_d = psel_i & ~penable_i;
		err_d = psel_i & ~penable_i & ~rd_ok;
		rdo_d = (psel_i & ~penable_i & ~pwrite_i) ? rd_v : 32'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes and hardware updates
	always_comb begin
		sel_d = sel_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		cmd_d = cmd_q;
		div_d = div_q;
		mode_d = mode_q;
		fix_d = fix_q;
		pdn_d = pdn_q;
		te_d = te_q;
		rst_d = rst_q;
		rcnt_d = rcnt_q;
		lock_d = lock_q;
		csel_d = csel_q;
		start_d = 1'b0;
		// engine completion; a new command cannot collide since busy blocks it
		if (eng_done) begin
			cmd_d = 8'h00;
			if (cmd_q == CMD_READ) begin
				rdat_d = eng_rdata;
			end
		end
		if (rst_q) begin
			if (rcnt_q == 16'h0000) begin
				rst_d = 1'b0;
			end else begin
				rcnt_d = rcnt_q - 16'h0001;
			end
		end
		if (wr) begin
			case (idx)
				IDX_REG_SEL: if (pstrb_i[0]) sel_d = pwdata_i[4:0];
				IDX_WDATA_LO: begin
					if (pstrb_i[0]) wdat_d[7:0] = pwdata_i[7:0];
					if (pstrb_i[1]) wdat_d[15:8] = pwdata_i[15:8];
				end
				IDX_WDATA_HI: if (pstrb_i[0]) wdat_d[15:8] = pwdata_i[7:0];
				IDX_ACC_CMD: begin
					// only a legal command on an idle engine is accepted
					if (pstrb_i[0] && cmd_q == 8'h00 && (pwdata_i[7:0] == CMD_WRITE || pwdata_i[7:0] == CMD_READ)) begin
						cmd_d = pwdata_i[7:0];
						start_d = 1'b1;
					end
				end
				IDX_DIV: if (pstrb_i[0]) div_d = pwdata_i[7:0];
				IDX_MODE: if (pstrb_i[0] && !lock_q) mode_d = pwdata_i[2:0];
				IDX_PWR: begin
					if (pstrb_i[0] && !lock_q) begin
						fix_d = pwdata_i[PWR_FIX_BIT];
						pdn_d = pwdata_i[PWR_PDN_BIT];
						te_d = pwdata_i[PWR_TE_BIT];
						if (pwdata_i[PWR_RST_BIT]) begin
							rst_d = 1'b1;
							rcnt_d = 16'(RST_CYC - 1);
						end
					end
				end
				IDX_LOCK: if (pstrb_i[0]) lock_d = pwdata_i[0];
				IDX_SYSCFG: if (pstrb_i[0]) csel_d = pwdata_i[0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered phy control outputs follow the next register state
	always_comb begin
		an_d = ~mode_d[2];
		s100_d = mode_d[2] & ~mode_d[1];
		fdx_d = mode_d[2] & ~mode_d[0];
		teo_d = te_d & (mode_d == 3'b000);
		// clock falls back to the selected rate once reset and power-down end
		c25_d = pdn_d | rst_d | csel_d;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_q <= 5'h00;
			wdat_q <= 16'h0000;
			rdat_q <= 16'h0000;
			cmd_q <= 8'h00;
			div_q <= DIV_RST;
			mode_q <= 3'h0;
			fix_q <= PWR_RST[PWR_FIX_BIT];
			pdn_q <= PWR_RST[PWR_PDN_BIT];
			te_q <= PWR_RST[PWR_TE_BIT];
			rst_q <= PWR_RST[PWR_RST_BIT];
			rcnt_q <= 16'h0000;
			lock_q <= LOCK_RST;
			csel_q <= 1'b0;
			start_q <= 1'b0;
			rdo_q <= 32'h0;
			rdy_q <= 1'b0;
			err_q <= 1'b0;
			an_q <= 1'b1;
			s100_q <= 1'b0;
			fdx_q <= 1'b0;
			teo_q <= 1'b0;
			c25_q <= 1'b0;
		end else begin
			sel_q <= sel_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			cmd_q <= cmd_d;
			div_q <= div_d;
			mode_q <= mode_d;
			fix_q <= fix_d;
			pdn_q <= pdn_d;
			te_q <= te_d;
			rst_q <= rst_d;
			rcnt_q <= rcnt_d;
			lock_q <= lock_d;
			csel_q <= csel_d;
			start_q <= start_d;
			rdo_q <= rdo_d;
			rdy_q <= rdy_d;
			err_q <= err_d;
			an_q <= an_d;
			s100_q <= s100_d;
			fdx_q <= fdx_d;
			teo_q <= teo_d;
			c25_q <= c25_d;
		end
	end

	assign prdata_o = rdo_q;
	assign pready_o = rdy_q;
	assign pslverr_o = err_q;
	assign phy_mode_o = mode_q;
	assign autoneg_o = an_q;
	assign speed100_o = s100_q;
	assign full_dpx_o = fdx_q;
	assign ten_base_te_o = teo_q;
	assign phy_power_down_o = pdn_q;
	assign phy_hw_reset_o = rst_q;
	assign core_clk_25m_o = c25_q;

	////////////////////////////////////////////////////////////////////////////////
	// frame engine
	pma_mdio_eng #(
		.PHY_ADDR(PHY_ADDR)
	) u_eng (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.start_i(start_q),
		.op_read_i(cmd_q == CMD_READ),
		.div_sel_i(div_q),
		.reg_i(sel_q),
		.wdata_i(wdat_q),
		.done_o(eng_done),
		.rdata_o(eng_rdata),
		.mdc_o(mdc_o),
		.mdio_o(mdio_o),
		.mdio_oe_o(mdio_oe_o),
		.mdio_i(mdio_i)
	);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_cmd_wr(logic [7:0] v);
		wr && idx == IDX_ACC_CMD && pstrb_i[0] && pwdata_i[7:0] == v && cmd_q == 8'h00;
	endsequence

	sequence s_start_wr;
		start_q && cmd_q == CMD_WRITE ##1 mdio_oe_o;
	endsequence

	start_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_cmd_wr(CMD_WRITE) |=> s_start_wr) else $error("write command did not start a frame");
	start_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_cmd_wr(CMD_READ) |=> start_q && cmd_q == CMD_READ) else $error("read command did not start");
	cmd_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		eng_done |=> cmd_q == 8'h00) else $error("command not cleared after access");
	read_capture_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		eng_done && cmd_q == CMD_READ |=> rdat_q == $past(eng_rdata)) else $error("read data not captured");
	lock_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && lock_q && (idx == IDX_MODE || idx == IDX_PWR) |=> $stable(mode_q) && $stable(pdn_q) && $stable(te_q))
		else $error("locked control register changed");
	mode_echo_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		psel_i && !penable_i && !pwrite_i && idx == IDX_LINK_STATE |=> prdata_o[5:3] == $past(mode_q))
		else $error("status does not show mode");
	pdn_clk_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		pdn_q |-> core_clk_25m_o) else $error("power-down without 25MHz clock");
	sysclk_select_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!pdn_q && !rst_q |-> core_clk_25m_o == csel_q) else $error("clock does not follow select");
	te_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ten_base_te_o |-> mode_q == 3'b000 && te_q) else $error("10BASE-Te outside mode 000");
	rst_clk_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_q |-> core_clk_25m_o && phy_hw_reset_o) else $error("phy reset without 25MHz clock");
	rst_end_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_q && rcnt_q == 16'h0000 && !wr |=> !rst_q && core_clk_25m_o == (pdn_q | csel_q))
		else $error("phy reset did not end");

	////////////////////////////////////////////////////////////////////////////////
	// register side and phy control outputs
	sequence s_pwr_wr;
		wr && idx == IDX_PWR && pstrb_i[0] && !lock_q;
	endsequence

	sequence s_rst_req;
		s_pwr_wr ##0 pwdata_i[PWR_RST_BIT];
	endsequence

	// a reset request also restarts a reset already running
	rst_load_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_rst_req |=> rst_q && rcnt_q == 16'(RST_CYC - 1))
		else $error("phy reset not started");

	pdn_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		s_pwr_wr |=> pdn_q == $past(pwdata_i[PWR_PDN_BIT]) && te_q == $past(pwdata_i[PWR_TE_BIT]))
		else $error("power bits not stored");

	rst_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_q && rcnt_q != 16'h0000 |=> rst_q)
		else $error("phy reset ended early");

	rst_count_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rst_q && rcnt_q != 16'h0000 && !wr |=> rcnt_q == $past(rcnt_q) - 16'h0001)
		else $error("phy reset counter skipped");

	mode_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_MODE && pstrb_i[0] && !lock_q |=> phy_mode_o == $past(pwdata_i[2:0]))
		else $error("unlocked mode write lost");

	// decoded outputs must agree with the stored field in every cycle
	mode_decode_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		1'b1 |-> autoneg_o == !phy_mode_o[2] && speed100_o == (phy_mode_o[2:1] == 2'b10)
			&& full_dpx_o == (phy_mode_o[2] && !phy_mode_o[0])) else $error("mode decode wrong");

	te_on_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		te_q && mode_q == 3'b000 |-> ten_base_te_o)
		else $error("10BASE-Te not enabled");

	sel_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_REG_SEL && pstrb_i[0] |=> sel_q == $past(pwdata_i[4:0]))
		else $error("register select not stored");

	wdat_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_WDATA_LO && pstrb_i[1:0] == 2'b11 |=> wdat_q == $past(pwdata_i[15:0]))
		else $error("write data not stored");

	rdata_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!(eng_done && cmd_q == CMD_READ) |=> $stable(rdat_q))
		else $error("read data changed without a read");

	rdata_bus_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		psel_i && !penable_i && !pwrite_i && idx == IDX_RDATA_LO |=> prdata_o == {16'h0000, $past(rdat_q)})
		else $error("read data register misread");

	// a busy command register must not be overwritten by a late request
	busy_refuse_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_ACC_CMD && cmd_q != 8'h00 && !eng_done |=> cmd_q == $past(cmd_q))
		else $error("busy command overwritten");

	bad_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_ACC_CMD && cmd_q == 8'h00 && pwdata_i[7:0] != CMD_WRITE && pwdata_i[7:0] != CMD_READ
			|=> cmd_q == 8'h00 && !start_q) else $error("illegal command accepted");

	eng_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		start_q |-> cmd_q == CMD_WRITE || cmd_q == CMD_READ)
		else $error("frame started without command");

	lock_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_LOCK && pstrb_i[0] |=> lock_q == $past(pwdata_i[0]))
		else $error("lock flag not stored");

	csel_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
		wr && idx == IDX_SYSCFG && pstrb_i[0] |=> csel_q == $past(pwdata_i[0]))
		else $error("clock select not stored");
endmodule : pma_top

/* sim/pma_phy_model.sv */
// behavioural phy management slave: 32 registers of 16 bits behind the serial frame
`timescale 1ns/1ps
module pma_phy_model #(
	parameter logic [4:0] PHY_ADDR = 5'h01
) (
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic oe_o
);
	logic [15:0] mem [32];
	logic [11:0] hdr = 12'h000;
	logic [15:0] dat = 16'h0000;
	logic prev1 = 1'b0;
	logic prev0 = 1'b0;
	int cnt = 0;
	wire rd_sel = (hdr[11:10] == 2'b10) && (hdr[9:5] == PHY_ADDR);
	initial begin
		oe_o = 1'b0;
		mdio_o = 1'b1;
		for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
	end
	////////////////////////////////////////////////////////////////////////
	// hold-off after each frame keeps trailing data bits from faking a start
	always @(posedge mdc_i) begin
		if (cnt < 0) cnt <= cnt + 1;
		else if (cnt == 0) begin
			if (prev1 && !prev0 && mdio_i) cnt <= 1;
		end else if (cnt <= 12) begin
			hdr <= {hdr[10:0], mdio_i};
			cnt <= cnt + 1;
		end else if (cnt < 30) begin
			if (cnt >= 15) dat <= {dat[14:0], mdio_i};
			cnt <= cnt + 1;
		end else begin
			if (hdr[11:10] == 2'b01 && hdr[9:5] == PHY_ADDR) mem[hdr[4:0]] <= {dat[14:0], mdio_i};
			cnt <= -24;
		end
		prev1 <= prev0;
		prev0 <= mdio_i;
	end
	// read data launched on the falling edge, second turnaround bit driven low
	always @(negedge mdc_i) begin
		oe_o <= rd_sel && cnt >= 14 && cnt <= 30;
		mdio_o <= (cnt <= 14) ? 1'b0 : mem[hdr[4:0]][30 - cnt];
	end
endmodule : pma_phy_model

/* sim/phy_mgmt_access_ctrl_tb_top.sv */
// self-checking bench: apb traffic, phy frames, mode, power and reset control
`timescale 1ns/1ps
module phy_mgmt_access_ctrl_tb_top;
	import pma_pkg::*;
	localparam int RC = 5;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [ADDR_W-1:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [3:0] pstrb_i = 4'hF;
	logic [3:0] st = 4'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, mdc_o, mdio_o, mdio_oe_o, mdio_i, m_d, m_oe;
	logic [2:0] phy_mode_o;
	logic autoneg_o, speed100_o, full_dpx_o, ten_base_te_o, phy_power_down_o, phy_hw_reset_o, core_clk_25m_o;
	logic [31:0] rv;
	logic ev;
	logic mdc_q = 1'b0;
	int err_total = 0;
	int total_checks = 0;
	int hp = 0;
	int hc = 0;
	always #5 clk_i = ~clk_i;
	// released line floats high through the pull-up
	assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_d : 1'b1);
	pma_top #(.RST_CYC(RC), .PHY_ADDR(5'h01)) pma_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .phy_cable_off_i(st[3]),
		.phy_half_dpx_i(st[2]), .phy_speed10_i(st[1]), .phy_link_i(st[0]), .mdc_o(mdc_o), .mdio_o(mdio_o),
		.mdio_oe_o(mdio_oe_o), .mdio_i(mdio_i), .phy_mode_o(phy_mode_o), .autoneg_o(autoneg_o),
		.speed100_o(speed100_o), .full_dpx_o(full_dpx_o), .ten_base_te_o(ten_base_te_o),
		.phy_power_down_o(phy_power_down_o), .phy_hw_reset_o(phy_hw_reset_o), .core_clk_25m_o(core_clk_25m_o));
	pma_phy_model #(.PHY_ADDR(5'h01)) pma_phy_model_inst (.mdc_i(mdc_o), .mdio_i(mdio_i), .mdio_o(m_d), .oe_o(m_oe));
	// half period of the management clock, in core cycles
	always @(posedge clk_i) begin
		mdc_q <= mdc_o;
		if (mdc_q != mdc_o) begin
			hp <= hc;
			hc <= 1;
		end else hc <= hc + 1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (err_total == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rv = prdata_o;
		ev = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 20) begin
			err_total++;
			stop_test();
		end
	endtask : apb
	task automatic rd(input logic [13:0] idx);
		apb(1'b0, idx, 32'h0);
	endtask : rd
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(IDX_ACC_CMD);
			n++;
		end while (rv !== 32'h0 && n < 5000);
		if (n >= 5000) begin
			err_total++;
			stop_test();
		end
	endtask : wait_idle
	////////////////////////////////////////////////////////////////////////
	initial begin
		int c1, c2;
		logic [15:0] d;
		logic [4:0] r;
		logic [7:0] dv;
		logic [2:0] m;
		void'($urandom(58201));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		rd(IDX_DIV); chk(rv, 32'h01);
		rd(IDX_PWR); chk(rv, 32'h40);
		rd(IDX_RDATA_LO); chk(rv, 32'h0);
		rd(IDX_MODE); chk(rv, 32'h0);
		chk({phy_mode_o, autoneg_o}, 4'b0001);
		rd(14'h3FFF); chk(ev, 1'b1);
		apb(1'b1, IDX_ACC_CMD, 32'h03);
		rd(IDX_ACC_CMD); chk(rv, 32'h0);
		// divider 0 runs the full write and read frames too; the fast frame is fine for the model
		for (int i = 0; i < 3; i++) begin
			dv = (i < 2) ? 8'(i) : 8'(2 + $urandom_range(253));
			r = 5'($urandom);
			d = 16'($urandom);
			apb(1'b1, IDX_DIV, {24'h0, dv});
			apb(1'b1, IDX_REG_SEL, {24'h0, 3'b111, r});
			rd(IDX_REG_SEL); chk(rv, {27'h0, r});
			apb(1'b1, IDX_WDATA_LO, {16'h0, d});
			rd(IDX_WDATA_HI); chk(rv, {24'h0, d[15:8]});
			apb(1'b1, IDX_ACC_CMD, 32'(CMD_WRITE));
			apb(1'b1, IDX_ACC_CMD, 32'(CMD_READ));
			rd(IDX_ACC_CMD); chk(rv, 32'(CMD_WRITE));
			wait_idle();
			chk(32'(pma_phy_model_inst.mem[r]), 32'(d));
			chk(32'(hp), 32'(16 << i));
			pma_phy_model_inst.mem[r] = ~d;
			apb(1'b1, IDX_ACC_CMD, 32'(CMD_READ));
			wait_idle();
			rd(IDX_RDATA_LO); chk(rv, {16'h0, ~d});
			rd(IDX_RDATA_HI); chk(rv, {24'h0, ~d[15:8]});
		end
		for (int k = 0; k < 8; k++) begin
			m = k[2:0];
			st <= 4'($urandom);
			apb(1'b1, IDX_MODE, {29'h0, m});
			apb(1'b1, IDX_PWR, 32'h48);
			repeat (2) @(posedge clk_i);
			chk({phy_mode_o, autoneg_o, speed100_o, full_dpx_o}, {m, ~m[2], m[2:1] == 2'b10, m[2] & ~m[0]});
			chk(ten_base_te_o, m == 3'b000);
			rd(IDX_LINK_STATE); chk(rv, {24'h0, st[3], 1'b0, m, st[2:0]});
		end
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, IDX_SYSCFG, {31'h0, k[0]});
			apb(1'b1, IDX_PWR, {25'h1, k[1], 5'h0});
			repeat (2) @(posedge clk_i);
			chk({phy_power_down_o, core_clk_25m_o}, {k[1], k[1] | k[0]});
		end
		apb(1'b1, IDX_SYSCFG, 32'h0);
		apb(1'b1, IDX_PWR, 32'h40);
		apb(1'b1, IDX_PWR, 32'h41);
		c1 = 0;
		c2 = 0;
		repeat (40) begin
			@(posedge clk_i);
			c1 += int'(phy_hw_reset_o === 1'b1 && core_clk_25m_o === 1'b1);
			c2 += int'(core_clk_25m_o === 1'b1);
		end
		chk(32'(c1), 32'(RC));
		chk(32'(c2), 32'(RC));
		rd(IDX_PWR); chk(rv, 32'h40);
		apb(1'b1, IDX_MODE, 32'h0);
		apb(1'b1, IDX_LOCK, 32'h1);
		apb(1'b1, IDX_MODE, 32'h7);
		apb(1'b1, IDX_PWR, 32'h61);
		repeat (2) @(posedge clk_i);
		chk({phy_mode_o, phy_power_down_o, phy_hw_reset_o}, 5'b0);
		apb(1'b1, IDX_LOCK, 32'h0);
		apb(1'b1, IDX_MODE, 32'h7);
		repeat (2) @(posedge clk_i);
		chk(phy_mode_o, 3'b111);
		apb(1'b1, IDX_DIV, 32'h01);
		stop_test();
	end
endmodule : phy_mgmt_access_ctrl_tb_top
